/* File: core/nobl_pkg.sv */
package nobl_pkg;

  // ----------------------------------------
  // Command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_SETF = 8'h1f;
  localparam logic [7:0] OP_GETF = 8'h0f;
  localparam logic [7:0] OP_PEXE = 8'h10;
  localparam logic [7:0] OP_PREAD = 8'h13;
  localparam logic [7:0] OP_BERASE = 8'hd8;
  localparam logic [7:0] OP_RESET = 8'hff;

  // ----------------------------------------
  // Feature addresses, bit positions, resets
  // ----------------------------------------
  localparam logic [7:0] FA_LOCK = 8'ha0;
  localparam logic [7:0] FA_CFG = 8'hb0;
  localparam logic [7:0] FA_STAT = 8'hc0;
  localparam int LOCK_WGUARD = 7;
  localparam int LOCK_RS2 = 5;
  localparam int LOCK_RS0 = 3;
  localparam int LOCK_INV = 2;
  localparam int LOCK_CMP = 1;
  localparam int CFG_OTPLOCK = 7;
  localparam int CFG_OTPACC = 6;
  localparam int CFG_ECC = 4;
  localparam int CFG_QUAD = 0;
  localparam int STAT_PFAULT = 3;
  localparam int STAT_EFAULT = 2;
  localparam int STAT_WLATCH = 1;
  localparam int STAT_PEND = 0;
  localparam logic [7:0] LOCK_RST = 8'h38;
  localparam logic [7:0] LOCK_WMASK = 8'hbe;
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] CFG_WMASK = 8'hd1;

  // ----------------------------------------
  // Array geometry and markers
  // ----------------------------------------
  localparam int ROW_W = 17;
  localparam int PAGE_BITS = 6;
  localparam logic [11:0] BLK_TOTAL = 12'h800;
  localparam logic [11:0] BLK_LAST = 12'h7ff;
  localparam logic [2:0] OTP_PAGES = 3'h4;
  localparam logic [7:0] BAD_MARK = 8'h00;
  localparam logic [7:0] GOOD_MARK = 8'hff;
  localparam logic [11:0] SPARE_FIRST = 12'h800;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int BUSY_NS = 80;
  localparam logic [3:0] BUSY_CYC = 4'(BUSY_NS / CLK_NS);

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] faddr;
    logic [7:0] fdata;
    logic [23:0] row;
  } nobl_cmd_s;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] cfg;
    logic [7:0] stat;
  } nobl_feat_s;

  typedef struct packed {
    logic prog;
    logic erase;
    logic read;
    logic otp_sel;
    logic [ROW_W-1:0] row;
  } nobl_arr_s;

  function automatic logic has_row(input logic [7:0] op);
    has_row = (op == OP_PEXE) || (op == OP_PREAD) || (op == OP_BERASE);
  endfunction

endpackage

/* File: core/nobl_range.sv */
`timescale 1ns/1ps
module nobl_range (
  // Lock feature and target row
  input wire logic [7:0] lock_in,
  input wire logic [nobl_pkg::ROW_W-1:0] row_in,
  // Verdict
  output logic locked_out
);
  import nobl_pkg::*;

  logic [2:0] sel;
  logic [11:0] size;
  logic [11:0] lo;
  logic [11:0] hi;
  logic [11:0] blk;
  logic any;

  // Bounds are kept in blocks; every documented edge is block aligned
  always_comb begin
    sel = lock_in[LOCK_RS2:LOCK_RS0];
    // Widened first, so the shift count does not wrap for selects 4 to 6
    size = 12'h001 << ({1'b0, sel} + 4'h4);
    lo = 12'h000;
    hi = 12'h000;
    any = 1'b1;
    if (sel == 3'h0) begin
      any = 1'b0; // RL16
    end else if (sel == 3'h7) begin
      hi = BLK_LAST; // RL16
    end else if (lock_in[LOCK_CMP] && sel == 3'h6) begin
      hi = 12'h000; // RL21
    end else if (!lock_in[LOCK_CMP] && !lock_in[LOCK_INV]) begin
      lo = BLK_TOTAL - size; // RL17
      hi = BLK_LAST;
    end else if (!lock_in[LOCK_CMP]) begin
      hi = size - 12'h001; // RL18
    end else if (!lock_in[LOCK_INV]) begin
      hi = BLK_LAST - size; // RL19
    end else begin
      lo = size; // RL20
      hi = BLK_LAST;
    end
    blk = {1'b0, row_in[ROW_W-1:PAGE_BITS]}; // RL25
    locked_out = any && (blk >= lo) && (blk <= hi);
  end

endmodule

/* File: core/nobl_link.sv */
`timescale 1ns/1ps
module nobl_link (
  // Serial pins
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  input wire logic rstn_in,
  // Feature mirror from the core domain
  input wire nobl_pkg::nobl_feat_s feat_in,
  // Command towards the core domain
  output nobl_pkg::nobl_cmd_s cmd_out,
  output logic cmd_tgl_out,
  // Serial output
  output logic miso_out,
  output logic miso_oe_out
);
  import nobl_pkg::*;

  logic frame_rst_n;
  nobl_feat_s fs1_q;
  nobl_feat_s fs2_q;
  logic [6:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic [2:0] byte_q, byte_d;
  logic [7:0] out_q, out_d;
  logic oen_q, oen_d;
  nobl_cmd_s cmd_q, cmd_d;
  logic tgl_q, tgl_d;
  logic [7:0] rx;

  // Frame state dies with chip select; the clock may stop between frames
  assign frame_rst_n = rstn_in & ~spi_cs_n_in;

  function automatic logic [7:0] feat_pick(input nobl_feat_s f, input logic [7:0] a);
    feat_pick = (a == FA_LOCK) ? f.lock : (a == FA_CFG) ? f.cfg : (a == FA_STAT) ? f.stat : 8'h00;
  endfunction

  always_comb begin
    rx = {sh_q, spi_mosi_in};
    sh_d = rx[6:0];
    bit_d = bit_q + 3'h1;
    byte_d = byte_q;
    cmd_d = cmd_q;
    tgl_d = tgl_q;
    oen_d = oen_q;
    out_d = oen_q ? {out_q[6:0], out_q[7]} : out_q;
    if (bit_q == 3'h7 && byte_q != 3'h4) begin
      byte_d = byte_q + 3'h1;
      case (byte_q)
        3'h0: begin
          cmd_d.op = rx;
          if (rx == OP_WREN || rx == OP_WRDI || rx == OP_RESET) begin
            tgl_d = ~tgl_q;
          end
        end
        3'h1: begin
          cmd_d.faddr = rx;
          cmd_d.row[23:16] = rx;
          if (cmd_q.op == OP_GETF) begin
            oen_d = 1'b1;
            out_d = feat_pick(fs2_q, rx);
          end
        end
        3'h2: begin
          cmd_d.fdata = rx;
          cmd_d.row[15:8] = rx;
          if (cmd_q.op == OP_SETF) begin
            tgl_d = ~tgl_q; // RL22
          end
        end
        3'h3: begin
          cmd_d.row[7:0] = rx;
          if (has_row(cmd_q.op)) begin
            tgl_d = ~tgl_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge spi_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sh_q <= 7'h00;
      bit_q <= 3'h0;
      byte_q <= 3'h0;
      out_q <= 8'h00;
      oen_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      out_q <= out_d;
      oen_q <= oen_d;
    end
  end

  // Toggle and command outlive the frame so the core sees each event once
  always_ff @(posedge spi_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_q <= '0;
      tgl_q <= 1'b0;
      fs1_q <= '0;
      fs2_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      tgl_q <= tgl_d;
      fs1_q <= feat_in;
      fs2_q <= fs1_q;
    end
  end

  always_ff @(negedge spi_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      miso_out <= out_q[7];
      miso_oe_out <= oen_q;
    end
  end

  assign cmd_out = cmd_q;
  assign cmd_tgl_out = tgl_q;

endmodule

/* File: core/nobl_core.sv */
`timescale 1ns/1ps
// Overview of operation
// RL1 - Four OTP pages 00h-03h, programmed only in ascending order while unlocked.
// RL2 - OTP lock bit is clear as shipped, so the OTP area starts writable.
// RL3 - Access bit 0 means main array; access 1 with lock 0 routes to OTP.
// RL4 - Access and lock set, then program-execute 10h, locks OTP permanently.
// RL5 - Lock bit found set at power-on allows OTP reads only, no programs.
// RL6 - OTP pages are never erased by any erase command.
// RL7 - Host locks OTP with set-features, write-enable, then program-execute.
// RL8 - Internal ECC applies to OTP pages exactly as to main pages.
// RL9 - OTP reads use page-read 13h then a cache-read command.
// RL10 - Factory bad blocks show 00h at spare byte 2048; good blocks FFh.
// RL11 - Host scans first spare byte of each block and avoids non-FFh blocks.
// RL12 - Power-up sets range select to 111 and clears invert, complement, guard.
// RL13 - Guard bit with guard pin low freezes the writable protection bits.
// RL14 - Program or erase on locked block keeps pending low and sets fault.
// RL15 - Guard pin works only while quad enable bit is 0.
// RL16 - Range select 000 unlocks all; 111 locks all rows.
// RL17 - No complement, no invert: upper 1/64 to 1/2 locked.
// RL18 - No complement, invert: lower 1/64 to 1/2 locked.
// RL19 - Complement, no invert: lower 63/64 to 3/4 locked.
// RL20 - Complement and invert: upper 63/64 to 3/4 locked.
// RL21 - Complement with select 110 locks only block zero.
// RL22 - With pin not low, set-features A0h changes protection bits.
// RL23 - Program fault also for protected targets; cleared at program-execute or reset.
// RL24 - Write-enable sets the write latch, write-disable clears it.
// RL25 - Lock check uses upper row bits as block, low six as page.
module nobl_core (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Serial link
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Guard pin and non-volatile lock
  input wire logic write_guard_pin_n_in,
  input wire logic otp_fuse_in,
  output logic otp_fuse_burn_out,
  output logic otp_lock_state_out,
  // Array side
  input wire logic factory_bad_in,
  output nobl_pkg::nobl_arr_s array_req_out,
  output logic [7:0] spare_mark_out,
  output logic ecc_enable_out,
  output logic operation_pending_out
);
  import nobl_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } nobl_state_e;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  nobl_cmd_s link_cmd;
  logic link_tgl;
  nobl_feat_s feat_q, feat_d;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic wp_s1_q, wp_s2_q;
  logic cmd_fire;
  logic [7:0] lock_q, lock_d;
  logic [7:0] cfg_q, cfg_d;
  logic pf_q, pf_d;
  logic ef_q, ef_d;
  logic wl_q, wl_d;
  logic otps_q, otps_d;
  logic [2:0] onext_q, onext_d;
  logic fdone_q;
  logic burn_q, burn_d;
  nobl_arr_s arr_q, arr_d;
  logic [7:0] spare_q, spare_d;
  nobl_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic go;
  logic guard;
  logic otp_acc;
  logic row_locked;
  logic [ROW_W-1:0] row;
  logic [PAGE_BITS-1:0] page;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  nobl_link u_link (
    .spi_clk_in(spi_clk_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_mosi_in(spi_mosi_in),
    .rstn_in(rstn_in),
    .feat_in(feat_q),
    .cmd_out(link_cmd),
    .cmd_tgl_out(link_tgl),
    .miso_out(spi_miso_out),
    .miso_oe_out(spi_miso_oe_out)
  );

  // ----------------------------------------
  // Crossings
  // ----------------------------------------
  // The command word is held by the link for at least eight link clocks
  // after each toggle, far longer than the three-flop toggle path here.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      tgl_s1_q <= link_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      wp_s1_q <= write_guard_pin_n_in;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign cmd_fire = tgl_s2_q ^ tgl_s3_q;

  // ----------------------------------------
  // Protection decode
  // ----------------------------------------
  assign row = link_cmd.row[ROW_W-1:0];
  assign page = link_cmd.row[PAGE_BITS-1:0];
  assign otp_acc = cfg_q[CFG_OTPACC]; // RL3
  assign guard = lock_q[LOCK_WGUARD] & ~wp_s2_q & ~cfg_q[CFG_QUAD]; // RL15

  nobl_range u_range (
    .lock_in(lock_q),
    .row_in(row),
    .locked_out(row_locked)
  );

  // ----------------------------------------
  // Feature and command logic
  // ----------------------------------------
  always_comb begin
    lock_d = lock_q;
    cfg_d = cfg_q;
    pf_d = pf_q;
    ef_d = ef_q;
    wl_d = wl_q;
    otps_d = otps_q;
    onext_d = onext_q;
    burn_d = 1'b0;
    arr_d = '0;
    arr_d.row = arr_q.row;
    arr_d.otp_sel = arr_q.otp_sel;
    spare_d = spare_q;
    go = 1'b0;
    // Non-volatile lock is sampled once, the first cycle after release
    if (!fdone_q) begin
      otps_d = otp_fuse_in; // RL5
      cfg_d[CFG_OTPLOCK] = otp_fuse_in;
    end
    if (cmd_fire) begin
      case (link_cmd.op)
        OP_WREN: begin
          wl_d = 1'b1; // RL24
        end
        OP_WRDI: begin
          wl_d = 1'b0; // RL24
        end
        OP_RESET: begin
          pf_d = 1'b0; // RL23
          ef_d = 1'b0;
          wl_d = 1'b0;
          go = 1'b1;
        end
        OP_SETF: begin
          if (link_cmd.faddr == FA_LOCK && !guard) begin
            lock_d = link_cmd.fdata & LOCK_WMASK; // RL13 RL22
          end else if (link_cmd.faddr == FA_CFG) begin
            cfg_d = link_cmd.fdata & CFG_WMASK;
            cfg_d[CFG_OTPLOCK] = link_cmd.fdata[CFG_OTPLOCK] | otps_q;
          end
        end
        OP_PEXE: begin
          if (st_q == ST_IDLE) begin
            pf_d = 1'b0; // RL23
            if (wl_q) begin
              wl_d = 1'b0;
              if (otp_acc) begin
                if (otps_q) begin
                  pf_d = 1'b1; // RL5 RL23
                end else if (cfg_q[CFG_OTPLOCK]) begin
                  otps_d = 1'b1; // RL4 RL7
                  burn_d = 1'b1;
                  go = 1'b1;
                end else if (onext_q == OTP_PAGES || {3'h0, onext_q} != page) begin
                  pf_d = 1'b1; // RL1
                end else begin
                  onext_d = onext_q + 3'h1; // RL1
                  arr_d.prog = 1'b1;
                  arr_d.otp_sel = 1'b1;
                  arr_d.row = {{(ROW_W-PAGE_BITS){1'b0}}, page};
                  go = 1'b1;
                end
              end else if (row_locked) begin
                pf_d = 1'b1; // RL14
              end else begin
                arr_d.prog = 1'b1;
                arr_d.otp_sel = 1'b0;
                arr_d.row = row;
                go = 1'b1;
              end
            end
          end
        end
        OP_BERASE: begin
          if (st_q == ST_IDLE) begin
            ef_d = 1'b0;
            if (wl_q) begin
              wl_d = 1'b0;
              if (otp_acc || row_locked) begin
                ef_d = 1'b1; // RL6 RL14
              end else begin
                arr_d.erase = 1'b1;
                arr_d.otp_sel = 1'b0;
                arr_d.row = row;
                go = 1'b1;
              end
            end
          end
        end
        OP_PREAD: begin
          if (st_q == ST_IDLE) begin
            arr_d.read = 1'b1;
            arr_d.otp_sel = otp_acc; // RL9
            arr_d.row = otp_acc ? {{(ROW_W-PAGE_BITS){1'b0}}, page} : row;
            go = 1'b1;
            // Bad-block marker shown at the first spare byte of page 0
            if (!otp_acc && page == {PAGE_BITS{1'b0}}) begin
              spare_d = factory_bad_in ? BAD_MARK : GOOD_MARK; // RL10
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Busy sequencer
  // ----------------------------------------
  // Array timing lives outside; the pending flag only covers a fixed window
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        if (go) begin
          st_d = ST_BUSY;
          cnt_d = BUSY_CYC - 4'h1;
        end
      end
      ST_BUSY: begin
        if (cnt_q == 4'h0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        st_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
    pend_d = (st_d == ST_BUSY); // RL14
  end

  // ----------------------------------------
  // Feature mirror
  // ----------------------------------------
  // Lock bit reads back only once the lock has really been made
  always_comb begin
    feat_d.lock = lock_d;
    feat_d.cfg = cfg_d;
    feat_d.cfg[CFG_OTPLOCK] = otps_d;
    feat_d.stat = 8'h00;
    feat_d.stat[STAT_PFAULT] = pf_d;
    feat_d.stat[STAT_EFAULT] = ef_d;
    feat_d.stat[STAT_WLATCH] = wl_d;
    feat_d.stat[STAT_PEND] = pend_d;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_q <= LOCK_RST; // RL12
      cfg_q <= CFG_RST; // RL2
      pf_q <= 1'b0;
      ef_q <= 1'b0;
      wl_q <= 1'b0;
      otps_q <= 1'b0;
      onext_q <= 3'h0;
      fdone_q <= 1'b0;
      burn_q <= 1'b0;
      arr_q <= '0;
      spare_q <= GOOD_MARK;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
      feat_q <= '0;
    end else begin
      lock_q <= lock_d;
      cfg_q <= cfg_d;
      pf_q <= pf_d;
      ef_q <= ef_d;
      wl_q <= wl_d;
      otps_q <= otps_d;
      onext_q <= onext_d;
      fdone_q <= 1'b1;
      burn_q <= burn_d;
      arr_q <= arr_d;
      spare_q <= spare_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      feat_q <= feat_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign otp_fuse_burn_out = burn_q;
  assign otp_lock_state_out = otps_q;
  assign array_req_out = arr_q;
  assign spare_mark_out = spare_q;
  assign ecc_enable_out = cfg_q[CFG_ECC]; // RL8
  assign operation_pending_out = pend_q;

endmodule

/* File: dv/nobl_core_monitor.sv */
`timescale 1ns/1ps
module nobl_core_monitor (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Watched pins
  input wire logic spi_cs_n_in,
  input wire logic spi_miso_oe_out,
  input wire logic otp_fuse_burn_out,
  input wire logic otp_lock_state_out,
  input wire nobl_pkg::nobl_arr_s array_req_out,
  input wire logic operation_pending_out
);
  import nobl_pkg::*;
  logic req;
  assign req = array_req_out.prog | array_req_out.erase | array_req_out.read;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // Array requests and busy window
  // ----------------------------------------
  AST_REQ_START: assert property (req |-> operation_pending_out && !$past(operation_pending_out))
    else $error("array request without busy start");
  AST_PEND_CAUSE: assert property ($rose(operation_pending_out) |-> req || otp_fuse_burn_out)
    else $error("busy rose without an accepted request");
  AST_PEND_LEN: assert property ($rose(operation_pending_out) |-> operation_pending_out [*8] ##1 !operation_pending_out)
    else $error("busy window length wrong");
  AST_REQ_PULSE: assert property (req |=> !req)
    else $error("array request longer than one cycle");
  AST_BUSY_REFUSE: assert property (operation_pending_out && $past(operation_pending_out) |-> !req)
    else $error("request issued while busy");
  AST_NO_OTP_ERASE: assert property (array_req_out.erase |-> !array_req_out.otp_sel)
    else $error("erase reached the otp pages");
  // ----------------------------------------
  // OTP lock and serial output
  // ----------------------------------------
  AST_BURN_LOCK: assert property (otp_fuse_burn_out |-> ##[0:2] otp_lock_state_out)
    else $error("burn without lock state");
  AST_LOCK_KEEP: assert property (otp_lock_state_out |=> otp_lock_state_out)
    else $error("otp lock state dropped");
  AST_LOCKED_NO_PROG: assert property ($past(otp_lock_state_out) && array_req_out.prog |-> !array_req_out.otp_sel)
    else $error("program of locked otp pages");
  AST_OE_RELEASE: assert property ($rose(spi_cs_n_in) |-> ##[0:2] !spi_miso_oe_out)
    else $error("miso still driven after deselect");
  COV_PROG: cover property (array_req_out.prog);
  COV_ERASE: cover property (array_req_out.erase);
  COV_BURN: cover property (otp_fuse_burn_out);
endmodule

bind nobl_core nobl_core_monitor nobl_core_monitor_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out), .otp_fuse_burn_out(otp_fuse_burn_out),
  .otp_lock_state_out(otp_lock_state_out), .array_req_out(array_req_out),
  .operation_pending_out(operation_pending_out));

/* File: dv/nobl_spi_host.sv */
`timescale 1ns/1ps
module nobl_spi_host (
  // Serial pins
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in,
  input wire logic spi_miso_oe_in
);
  import nobl_pkg::*;
  logic last_q;
  logic miso_w;
  // A released line shows the opposite of its last level, so stale bits never pass
  always @(posedge spi_clk_out) if (spi_miso_oe_in) last_q <= spi_miso_in;
  assign miso_w = spi_miso_oe_in ? spi_miso_in : ~last_q;
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
    last_q = 1'b0;
  end
  // Mode 0; clock stands still outside frames
  task automatic frame(input logic [39:0] tx, input int nb, input bit rd, output logic [7:0] rx);
    int n;
    n = nb * 8 + (rd ? 8 : 0);
    rx = 8'h00;
    spi_cs_n_out = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      spi_mosi_out = (i < nb * 8) ? tx[39 - i] : ~spi_mosi_out;
      #24 spi_clk_out = 1'b1;
      if (i >= nb * 8) rx = {rx[6:0], miso_w};
      #24 spi_clk_out = 1'b0;
    end
    #24 spi_cs_n_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out;
    // Room for the command to cross into the core domain
    #240;
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rx;
    frame({OP_SETF, a, d, 16'h0000}, 3, 1'b0, rx);
  endtask
  task automatic getf(input logic [7:0] a, output logic [7:0] d);
    frame({OP_GETF, a, 24'h000000}, 2, 1'b1, d);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [16:0] row);
    logic [7:0] rx;
    frame({op, 7'h00, row, 8'h00}, (op == OP_WREN || op == OP_WRDI) ? 1 : 4, 1'b0, rx);
  endtask
endmodule

/* File: dv/nand_otp_and_block_lock_test.sv */
`timescale 1ns/1ps
module nand_otp_and_block_lock_test;
  import nobl_pkg::*;
  logic ref_clk_in, rstn_in, sclk, cs_n, mosi, miso, miso_oe, wg_n, fuse, burn, lock_st, bad, ecc, pend;
  logic [7:0] spare;
  nobl_arr_s req;
  logic last_sel;
  logic [16:0] last_row;
  int err_total, num_checks, n_prog, n_erase, n_read, n_burn;
  // Lock flag, block lock feature value, target row
  logic [25:0] tab [20] = '{{1'b0, 8'h06, 17'h1ffff}, {1'b1, 8'h3e, 17'h00000}, {1'b1, 8'h08, 17'h1f800},
    {1'b0, 8'h08, 17'h1f7ff}, {1'b1, 8'h30, 17'h10000}, {1'b0, 8'h30, 17'h0ffff}, {1'b1, 8'h0c, 17'h007ff},
    {1'b0, 8'h0c, 17'h00800}, {1'b1, 8'h34, 17'h0ffff}, {1'b0, 8'h34, 17'h10000}, {1'b1, 8'h0a, 17'h1f7ff},
    {1'b0, 8'h0a, 17'h1f800}, {1'b1, 8'h2a, 17'h17fff}, {1'b0, 8'h2a, 17'h18000}, {1'b1, 8'h0e, 17'h00800},
    {1'b0, 8'h0e, 17'h007ff}, {1'b1, 8'h2e, 17'h08000}, {1'b0, 8'h2e, 17'h07fff}, {1'b1, 8'h32, 17'h0003f},
    {1'b0, 8'h36, 17'h00040}};
  nobl_core nobl_core_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .spi_clk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .write_guard_pin_n_in(wg_n),
    .otp_fuse_in(fuse), .otp_fuse_burn_out(burn), .otp_lock_state_out(lock_st), .factory_bad_in(bad),
    .array_req_out(req), .spare_mark_out(spare), .ecc_enable_out(ecc), .operation_pending_out(pend));
  nobl_spi_host nobl_spi_host_i (.spi_clk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
    .spi_miso_in(miso), .spi_miso_oe_in(miso_oe));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Counted away from the launching edge, so each pulse is seen exactly once
  always @(negedge ref_clk_in) begin
    if (req.prog === 1'b1) begin
      n_prog++;
      last_sel = req.otp_sel;
      last_row = req.row;
    end
    if (req.erase === 1'b1) n_erase++;
    if (req.read === 1'b1) n_read++;
    if (burn === 1'b1) n_burn++;
  end
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    nobl_spi_host_i.getf(a, d);
    chk(d & m, exp);
  endtask
  // Program or erase attempt; fault bit checked is the one that belongs to the command
  task automatic try(input logic [7:0] op, input logic [16:0] row, input bit we, input int dp, input int de,
    input bit f);
    int p0, e0;
    logic [7:0] m;
    p0 = n_prog;
    e0 = n_erase;
    m = (op == OP_BERASE) ? 8'h04 : 8'h08;
    if (we) nobl_spi_host_i.cmd(OP_WREN, 17'h0);
    nobl_spi_host_i.cmd(op, row);
    chk(8'(n_prog - p0), 8'(dp));
    chk(8'(n_erase - e0), 8'(de));
    rd(FA_STAT, m, f ? m : 8'h00);
  endtask
  task automatic do_reset(input logic fz);
    @(negedge ref_clk_in);
    rstn_in = 1'b0;
    fuse = fz;
    repeat (10) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
  endtask
  task automatic close_out();
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    err_total++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int r0;
    rstn_in = 1'b0;
    wg_n = 1'b1;
    fuse = 1'b0;
    bad = 1'b0;
    err_total = 0;
    num_checks = 0;
    n_prog = 0;
    n_erase = 0;
    n_read = 0;
    n_burn = 0;
    last_sel = 1'b0;
    do_reset(1'b0);
    chk(spare, 8'hff);
    chk({7'h0, ecc}, 8'h01);
    rd(FA_LOCK, 8'hff, 8'h38);
    rd(FA_CFG, 8'hc0, 8'h00);
    try(OP_PEXE, 17'h00000, 1, 0, 0, 1);
    try(OP_BERASE, 17'h1ffff, 1, 0, 0, 1);
    for (int i = 0; i < 20; i++) begin
      nobl_spi_host_i.setf(FA_LOCK, tab[i][24:17]);
      try(OP_PEXE, tab[i][16:0], 1, tab[i][25] ? 0 : 1, 0, tab[i][25]);
    end
    try(OP_BERASE, 17'h0003f, 1, 0, 0, 1);
    try(OP_BERASE, 17'h00040, 1, 0, 1, 0);
    nobl_spi_host_i.cmd(OP_WREN, 17'h0);
    rd(FA_STAT, 8'h02, 8'h02);
    nobl_spi_host_i.cmd(OP_WRDI, 17'h0);
    rd(FA_STAT, 8'h02, 8'h00);
    try(OP_PEXE, 17'h00040, 0, 0, 0, 0);
    nobl_spi_host_i.setf(FA_LOCK, 8'h80);
    @(negedge ref_clk_in);
    wg_n = 1'b0;
    nobl_spi_host_i.setf(FA_LOCK, 8'h38);
    rd(FA_LOCK, 8'hff, 8'h80);
    nobl_spi_host_i.setf(FA_CFG, 8'h11);
    nobl_spi_host_i.setf(FA_LOCK, 8'hb8);
    rd(FA_LOCK, 8'hff, 8'hb8);
    nobl_spi_host_i.setf(FA_CFG, 8'h10);
    @(negedge ref_clk_in);
    wg_n = 1'b1;
    nobl_spi_host_i.setf(FA_LOCK, 8'h00);
    rd(FA_LOCK, 8'hff, 8'h00);
    nobl_spi_host_i.setf(FA_CFG, 8'h50);
    try(OP_PEXE, 17'h00001, 1, 0, 0, 1);
    try(OP_PEXE, 17'h00000, 1, 1, 0, 0);
    chk({7'h0, last_sel}, 8'h01);
    try(OP_PEXE, 17'h00001, 1, 1, 0, 0);
    try(OP_BERASE, 17'h00000, 1, 0, 0, 1);
    r0 = n_read;
    nobl_spi_host_i.cmd(OP_PREAD, 17'h00001);
    chk(8'(n_read - r0), 8'h01);
    nobl_spi_host_i.setf(FA_CFG, 8'hd0);
    nobl_spi_host_i.cmd(OP_WREN, 17'h0);
    nobl_spi_host_i.cmd(OP_PEXE, 17'h00002);
    chk({7'h0, lock_st}, 8'h01);
    chk(8'(n_burn), 8'h01);
    rd(FA_CFG, 8'h80, 8'h80);
    try(OP_PEXE, 17'h00002, 1, 0, 0, 1);
    nobl_spi_host_i.setf(FA_CFG, 8'h10);
    try(OP_PEXE, 17'h00080, 1, 1, 0, 0);
    chk({7'h0, last_sel}, 8'h00);
    chk(last_row[7:0], 8'h80);
    @(negedge ref_clk_in);
    bad = 1'b1;
    nobl_spi_host_i.cmd(OP_PREAD, 17'h00040);
    chk(spare, 8'h00);
    @(negedge ref_clk_in);
    bad = 1'b0;
    nobl_spi_host_i.cmd(OP_PREAD, 17'h00080);
    chk(spare, 8'hff);
    do_reset(1'b1);
    chk({7'h0, lock_st}, 8'h01);
    rd(FA_CFG, 8'h80, 8'h80);
    nobl_spi_host_i.setf(FA_LOCK, 8'h00);
    nobl_spi_host_i.setf(FA_CFG, 8'h50);
    try(OP_PEXE, 17'h00000, 1, 0, 0, 1);
    close_out();
  end
endmodule
